/* File: logic/pseq_pkg.sv */
// Purpose: shared constants and types for the program sequencer
// Assumes: one 50 MHz clock that stands for the oscillator input
// Notes:   every offset, width, vector and count used by the design lives here
`default_nettype none

package pseq_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int PC_W      = 12;          // program counter width
	localparam int INSTR_W   = 13;          // instruction word width
	localparam int PROG_WORDS = 4096;       // program store depth
	localparam int NEAR_W    = 10;          // near target field width
	localparam int FAR_W     = 12;          // far target field width
	localparam int PB_W      = 4;           // page buffer width
	localparam int PAGE_LO   = 2;           // page select field, low bit
	localparam int PAGE_HI   = 3;           // page select field, high bit
	localparam int LOW_W     = 8;           // counter low byte width

	// ----------------------------------------------------------------
	// vectors and reset values
	// ----------------------------------------------------------------
	localparam logic [PC_W-1:0] VEC_RESET = 12'hFFF;
	localparam logic [PC_W-1:0] VEC_HW    = 12'h008;
	localparam logic [PC_W-1:0] VEC_SW    = 12'h002;
	localparam logic [PC_W-1:0] PC_ONE    = 12'h001;
	localparam logic [PB_W-1:0] PB_RESET  = 4'h0;

	// ----------------------------------------------------------------
	// return stack
	// ----------------------------------------------------------------
	localparam int                  STK_DEPTH = 5;
	localparam int                  STK_PTR_W = 3;
	localparam logic [STK_PTR_W-1:0] STK_LAST = 3'h4;
	localparam logic [STK_PTR_W-1:0] STK_ZERO = 3'h0;
	localparam logic [STK_PTR_W-1:0] STK_ONE  = 3'h1;

	// ----------------------------------------------------------------
	// instruction cycle divider
	// ----------------------------------------------------------------
	localparam int              CLK_HZ    = 50_000_000;
	localparam int              DIV_RATIO = 4;             // oscillator clocks per cycle
	localparam int              DIV_W     = 2;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV_RATIO - 1);
	localparam logic [DIV_W-1:0] DIV_ZERO = 2'h0;
	localparam logic [DIV_W-1:0] DIV_ONE  = 2'h1;

	// ----------------------------------------------------------------
	// sequencer state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PSEQ_RUN   = 2'b01,   // executing fetched instructions
		PSEQ_FLUSH = 2'b10    // second cycle of a branch, fetched word discarded
	} pseq_state_t;

endpackage

`default_nettype wire

/* File: logic/pseq_sequencer.sv */
// Purpose: program counter, paging and return-stack sequencer of an 8-bit core
// Assumes: the decoder presents one command per instruction cycle, on the same clock
// Notes:   clk stands for the oscillator input; the instruction cycle is an enable pulse
`default_nettype none

// Behaviour
// - The counter is 12 bits wide and addresses a 4K store of 13-bit instruction words.
// - After any reset the counter is loaded with FFFh and fetching starts there.
// - The block stays in reset for as long as the external reset pin is held low.
// - A taken hardware interrupt sends the counter to 008h.
// - A taken software interrupt sends the counter to 002h.
// - Near jumps and calls carry a 10-bit target that on its own stays within a 1K page.
// - Near branches take their page from buffer bits 3:2, which the program sets beforehand.
// - Every return reloads all 12 counter bits from the stack top, ignoring the buffer.
// - A five-level return stack serves calls and interrupts.
// - Instructions take one instruction cycle, branches take two.
// - The instruction cycle is the oscillator divided by four, shown on the output pin in RC mode.
// - Near branches form bits 11:10 from the buffer and 9:0 from the word, buffer unchanged.
// - Near and far calls push the address of the following instruction.
// - Far branches take 12 bits from the word and copy the page into buffer bits 3:2 only.
// - With no branch the counter steps by one each instruction cycle.
module pseq_sequencer
	import pseq_pkg::*;
(
	// clock and chip reset
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	// external reset pin, asynchronous to clk
	input  wire logic                 external_reset_n,
	// oscillator mode and output pin
	input  wire logic                 rc_mode,
	output logic                      osc_output_pin,
	// program store port
	output logic      [PC_W-1:0]      prog_addr,
	input  wire logic [INSTR_W-1:0]   instr_word,
	// decoded commands
	input  wire logic                 near_jump_instr,
	input  wire logic                 near_call_instr,
	input  wire logic                 far_jump_instr,
	input  wire logic                 far_call_instr,
	input  wire logic                 return_instr,
	input  wire logic                 sw_irq_take,
	input  wire logic                 hw_irq_take,
	// data path writes
	input  wire logic                 page_wr_en,
	input  wire logic [PB_W-1:0]      page_wr_data,
	input  wire logic                 low_wr_en,
	input  wire logic [LOW_W-1:0]     low_wr_data,
	// status toward the core
	output logic                      icycle_en,
	output logic                      exec_valid,
	output logic                      hw_irq_ack,
	output logic                      in_reset,
	output logic      [PB_W-1:0]      page_high_buffer,
	output logic      [LOW_W-1:0]     counter_low_byte
);

	// ----------------------------------------------------------------
	// external reset pin synchroniser
	// ----------------------------------------------------------------
	logic rst_s1;
	logic rst_s2;
	logic rst_s3;
	logic hold;
	logic next_hold;

	// the pin only counts once the second and third stages agree
	always_comb begin
		next_hold = hold;
		if (rst_s2 == rst_s3) begin
			next_hold = ~rst_s2;
		end
	end

	// stages reset low so the core stays held until the pin is seen high
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1 <= 1'b0;
			rst_s2 <= 1'b0;
			rst_s3 <= 1'b0;
			hold   <= 1'b1;
		end else begin
			rst_s1 <= external_reset_n;
			rst_s2 <= rst_s1;
			rst_s3 <= rst_s2;
			hold   <= next_hold;
		end
	end

	assign in_reset = hold;

	// ----------------------------------------------------------------
	// instruction cycle divider
	// ----------------------------------------------------------------
	logic [DIV_W-1:0] div_cnt;
	logic [DIV_W-1:0] next_div_cnt;
	logic             next_osc_out;

	// four oscillator clocks per instruction cycle; restarts on reset
	always_comb begin
		next_div_cnt = (div_cnt == DIV_LAST) ? DIV_ZERO : div_cnt + DIV_ONE;
		if (hold) begin
			next_div_cnt = DIV_ZERO;
		end
		next_osc_out = rc_mode & next_div_cnt[DIV_W-1];
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt        <= DIV_ZERO;
			osc_output_pin <= 1'b0;
		end else begin
			div_cnt        <= next_div_cnt;
			osc_output_pin <= next_osc_out;
		end
	end

	// one-clock pulse closing each instruction cycle
	assign icycle_en = (div_cnt == DIV_LAST) & ~hold;

	// ----------------------------------------------------------------
	// return stack
	// ----------------------------------------------------------------
	logic            stk_push;
	logic            stk_pop;
	logic [PC_W-1:0] stk_push_data;
	logic [PC_W-1:0] stk_top;

	pseq_stack u_stack (
		.clk       (clk),
		.rst_n     (rst_n),
		.clear     (hold),
		.push      (stk_push),
		.pop       (stk_pop),
		.push_data (stk_push_data),
		.top_data  (stk_top)
	);

	// ----------------------------------------------------------------
	// program counter, page buffer and branch state
	// ----------------------------------------------------------------
	logic [PC_W-1:0] pc;
	logic [PC_W-1:0] next_pc;
	logic [PB_W-1:0] page_buf;
	logic [PB_W-1:0] next_page_buf;
	pseq_state_t     state;
	pseq_state_t     next_state;
	logic            take;

	// commands count only at the end of a cycle that executes an instruction
	assign take       = icycle_en & (state == PSEQ_RUN);
	assign exec_valid = (state == PSEQ_RUN) & ~hold;
	assign hw_irq_ack = take & hw_irq_take;

	// priority: reset, hardware interrupt, software interrupt, return,
	// far branch, near branch, low-byte write, plain step
	always_comb begin
		next_pc       = pc;
		next_page_buf = page_buf;
		next_state    = state;
		stk_push      = 1'b0;
		stk_pop       = 1'b0;
		stk_push_data = pc;
		if (icycle_en) begin
			unique case (state)
				PSEQ_RUN: begin
					next_pc = pc + PC_ONE;
					if (page_wr_en) begin
						next_page_buf = page_wr_data;
					end
					if (hw_irq_take) begin
						// the word fetched at pc-1 is abandoned, so it is the one resumed
						stk_push      = 1'b1;
						stk_push_data = pc - PC_ONE;
						next_pc       = VEC_HW;
						next_state    = PSEQ_FLUSH;
					end else if (sw_irq_take) begin
						stk_push   = 1'b1;
						next_pc    = VEC_SW;
						next_state = PSEQ_FLUSH;
					end else if (return_instr) begin
						stk_pop    = 1'b1;
						next_pc    = stk_top;
						next_state = PSEQ_FLUSH;
					end else if (far_jump_instr || far_call_instr) begin
						stk_push      = far_call_instr;
						next_pc       = instr_word[FAR_W-1:0];
						next_page_buf[PAGE_HI:PAGE_LO] = instr_word[FAR_W-1:NEAR_W];
						next_state    = PSEQ_FLUSH;
					end else if (near_jump_instr || near_call_instr) begin
						stk_push   = near_call_instr;
						next_pc    = {page_buf[PAGE_HI:PAGE_LO], instr_word[NEAR_W-1:0]};
						next_state = PSEQ_FLUSH;
					end else if (low_wr_en) begin
						// computed jump: upper bits only ever come through the buffer
						next_pc    = {page_buf, low_wr_data};
						next_state = PSEQ_FLUSH;
					end
				end
				PSEQ_FLUSH: begin
					// second cycle of a branch: the target word is fetched, nothing runs
					next_pc    = pc + PC_ONE;
					next_state = PSEQ_RUN;
				end
			endcase
		end
		if (hold) begin
			next_pc       = VEC_RESET;
			next_page_buf = PB_RESET;
			next_state    = PSEQ_RUN;
			stk_push      = 1'b0;
			stk_pop       = 1'b0;
		end
	end

	// 12-bit counter over the 4K x 13 store
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pc       <= VEC_RESET;
			page_buf <= PB_RESET;
			state    <= PSEQ_RUN;
		end else begin
			pc       <= next_pc;
			page_buf <= next_page_buf;
			state    <= next_state;
		end
	end

	// ----------------------------------------------------------------
	// outputs straight from registers
	// ----------------------------------------------------------------
	assign prog_addr        = pc;
	assign counter_low_byte = pc[LOW_W-1:0];
	assign page_high_buffer = page_buf;

endmodule

`default_nettype wire

/* File: logic/pseq_stack.sv */
// Purpose: five-entry circular return-address stack
// Assumes: push and pop never arrive in the same cycle
// Notes:   overflow wraps over the oldest entry, underflow wraps too; no error is flagged
`default_nettype none

module pseq_stack
	import pseq_pkg::*;
(
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 clear,
	// requests
	input  wire logic                 push,
	input  wire logic                 pop,
	input  wire logic [PC_W-1:0]      push_data,
	// answer
	output logic      [PC_W-1:0]      top_data
);

	// ----------------------------------------------------------------
	// storage and pointer
	// ----------------------------------------------------------------
	logic [PC_W-1:0]      entry [0:STK_DEPTH-1];
	logic [STK_PTR_W-1:0] wr_ptr;
	logic [STK_PTR_W-1:0] next_wr_ptr;
	logic [STK_PTR_W-1:0] top_ptr;

	// newest entry sits one below the write pointer, wrapping at zero
	always_comb begin
		top_ptr = (wr_ptr == STK_ZERO) ? STK_LAST : wr_ptr - STK_ONE;
		top_data = entry[top_ptr];
	end

	// pointer moves circularly so a sixth push silently replaces the oldest
	always_comb begin
		next_wr_ptr = wr_ptr;
		if (clear) begin
			next_wr_ptr = STK_ZERO;
		end else if (push) begin
			next_wr_ptr = (wr_ptr == STK_LAST) ? STK_ZERO : wr_ptr + STK_ONE;
		end else if (pop) begin
			next_wr_ptr = top_ptr;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= STK_ZERO;
		end else begin
			wr_ptr <= next_wr_ptr;
		end
	end

	// one word per level, five levels
	genvar gi;
	generate
		for (gi = 0; gi < STK_DEPTH; gi++) begin : g_entry
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					entry[gi] <= '0;
				end else if (push && !clear && wr_ptr == STK_PTR_W'(gi)) begin
					entry[gi] <= push_data;
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

/* File: tb/pseq_rom_model.sv */
// Purpose: program store model answering the fetch address
// Assumes: the word fetched in one instruction cycle is executed in the next
// Notes:   fixed pattern contents so the bench predicts every word
`default_nettype none

module pseq_rom_model
	import pseq_pkg::*;
(
	// clock, reset and cycle timing
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic               icycle_en,
	// fetch port
	input  wire logic [PC_W-1:0]    prog_addr,
	output logic      [INSTR_W-1:0] instr_word
);
	timeunit 1ns;
	timeprecision 1ps;
	// word latched at the cycle pulse, so the executing word trails the fetch
	// address by one cycle; top bit set and address scrambled so a stuck bit shows
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			instr_word <= '0;
		end else if (icycle_en) begin
			instr_word <= {1'b1, prog_addr ^ 12'h05A5};
		end
	end
endmodule

`default_nettype wire

/* File: tb/pseq_sequencer_props.sv */
// Purpose: timing checks on the sequencer ports
// Assumes: one clock domain, reset rst_n
// Notes:   results allow for an external reset hold arriving mid-cycle
`default_nettype none

module pseq_sequencer_props
	import pseq_pkg::*;
(
	// clock and resets
	input wire logic                 clk,
	input wire logic                 rst_n,
	input wire logic                 external_reset_n,
	// fetch and commands
	input wire logic [PC_W-1:0]      prog_addr,
	input wire logic [INSTR_W-1:0]   instr_word,
	input wire logic                 near_jump_instr,
	input wire logic                 near_call_instr,
	input wire logic                 far_jump_instr,
	input wire logic                 far_call_instr,
	input wire logic                 return_instr,
	input wire logic                 sw_irq_take,
	input wire logic                 hw_irq_take,
	input wire logic                 page_wr_en,
	input wire logic                 low_wr_en,
	// status
	input wire logic                 icycle_en,
	input wire logic                 exec_valid,
	input wire logic                 in_reset,
	input wire logic [PB_W-1:0]      page_high_buffer
);
	timeunit 1ns;
	timeprecision 1ps;
	logic go;
	logic hi;
	logic br;
	// executing edge, higher-priority redirect, any branch
	assign go = icycle_en && exec_valid;
	assign hi = hw_irq_take || sw_irq_take || return_instr;
	assign br = hi || far_jump_instr || far_call_instr || near_jump_instr || near_call_instr
		|| low_wr_en;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_step; go && !br |=> in_reset || prog_addr == $past(prog_addr) + PC_ONE; endproperty
	a_step: assert property (p_step) else $error("counter did not step");
	property p_near; go && (near_jump_instr || near_call_instr) && !hi && !far_jump_instr
		&& !far_call_instr |=> in_reset || (prog_addr == {$past(page_high_buffer[3:2]),
		$past(instr_word[9:0])} && (page_high_buffer == $past(page_high_buffer) || $past(page_wr_en)));
	endproperty
	a_near: assert property (p_near) else $error("near target wrong");
	property p_far; go && (far_jump_instr || far_call_instr) && !hi |=> in_reset
		|| (prog_addr == $past(instr_word[11:0]) && page_high_buffer[3:2] == $past(instr_word[11:10]));
	endproperty
	a_far: assert property (p_far) else $error("far target wrong");
	property p_hw; go && hw_irq_take |=> in_reset || prog_addr == VEC_HW; endproperty
	a_hw: assert property (p_hw) else $error("hw vector wrong");
	property p_flush; go && br |=> !exec_valid [*4] ##1 (exec_valid || in_reset); endproperty
	a_flush: assert property (p_flush) else $error("branch length wrong");
	property p_div; icycle_en |=> !icycle_en [*3] ##1 (icycle_en || in_reset); endproperty
	a_div: assert property (p_div) else $error("cycle pulse not every fourth clock");
	property p_hold; !external_reset_n [*4] |=> in_reset && !icycle_en && !exec_valid; endproperty
	a_hold: assert property (p_hold) else $error("pin low did not hold");
	property p_vec; $fell(in_reset) |-> prog_addr == VEC_RESET && page_high_buffer == PB_RESET;
	endproperty
	a_vec: assert property (p_vec) else $error("reset vector wrong");
endmodule

bind pseq_sequencer pseq_sequencer_props props_u (.clk, .rst_n, .external_reset_n, .prog_addr,
	.instr_word, .near_jump_instr, .near_call_instr, .far_jump_instr, .far_call_instr,
	.return_instr, .sw_irq_take, .hw_irq_take, .page_wr_en, .low_wr_en, .icycle_en,
	.exec_valid, .in_reset, .page_high_buffer);

`default_nettype wire

/* File: tb/pseq_sequencer_tb.sv */
// Purpose: self-checking bench for the program sequencer
// Assumes: commands held until the executing edge
// Notes:   expected targets come from the store pattern
`default_nettype none

module pseq_sequencer_tb
	import pseq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_n = 0, ext_n = 1, rc = 0, pw = 0, lw = 0, osc, ice, ev, ack, inr, ak;
	logic [6:0] cmd = '0; // hw sw ret far_call_instr fjump ncall njump
	logic [3:0] pd = '0, pg;
	logic [7:0] ld = '0, lo;
	logic [PC_W-1:0] pa, p, xa, q[6];
	logic [INSTR_W-1:0] iw;
	int fail_count = 0, checks_done = 0, cyc = 0, n;
	always #10 clk = ~clk;
	pseq_rom_model rom_u (.clk(clk), .rst_n(rst_n), .icycle_en(ice), .prog_addr(pa),
		.instr_word(iw));
	pseq_sequencer dut_u (.clk, .rst_n, .external_reset_n(ext_n), .rc_mode(rc),
		.osc_output_pin(osc), .prog_addr(pa), .instr_word(iw), .near_jump_instr(cmd[0]),
		.near_call_instr(cmd[1]), .far_jump_instr(cmd[2]), .far_call_instr(cmd[3]),
		.return_instr(cmd[4]), .sw_irq_take(cmd[5]), .hw_irq_take(cmd[6]), .page_wr_en(pw),
		.page_wr_data(pd), .low_wr_en(lw), .low_wr_data(ld), .icycle_en(ice), .exec_valid(ev),
		.hw_irq_ack(ack), .in_reset(inr), .page_high_buffer(pg), .counter_low_byte(lo));
	function automatic logic [PC_W-1:0] wd(input logic [PC_W-1:0] a);
		return a ^ 12'h05A5;
	endfunction
	task automatic print_verdict;
		if (fail_count == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [PC_W-1:0] got, input logic [PC_W-1:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t got %h want %h", $time, got, exp);
		end
	endtask
	// hold the command up to the edge that executes it, release it one edge later;
	// xa is the address of the executing word, one behind the fetch address
	task automatic ex(input logic [6:0] c, input logic [3:0] d = 0, input logic w = 0,
		input logic l = 0, input logic [7:0] b = 0);
		logic go;
		go = 0;
		n = 0;
		@(posedge clk) {cmd, pd, pw, lw, ld} <= {c, d, w, l, b};
		while (!go && n < 40) begin
			@(negedge clk) {go, ak, xa} = {ice && ev, ack, pa - PC_ONE};
			@(posedge clk) n++;
		end
		if (!go) chk(0, 1);
		@(posedge clk) {cmd, pw, lw} <= '0;
		@(negedge clk);
	endtask
	task automatic t_branch;
		chk(pa, VEC_RESET);
		ex(0, 4'hB, 1); chk(pa, 12'h000);
		chk(PC_W'(pg), 12'h00B);
		ex(7'h01); chk(pa, {2'b10, 10'(wd(xa))});
		chk(PC_W'(pg), 12'h00B);
		ex(7'h08); p = xa; chk(pa, wd(xa));
		chk(PC_W'(pg), {8'h0, 2'(wd(xa) >> 10), 2'b11});
		ex(0); ex(7'h10); chk(pa, p + PC_ONE);
		ex(7'h04); chk(pa, wd(xa));
		ex(0, 0, 0, 1, 8'h3C); chk(pa, {pg, 8'h3C});
		chk(PC_W'(lo), 12'h03C);
	endtask
	task automatic t_irq;
		ex(7'h70); p = xa; chk(pa, VEC_HW); chk(PC_W'(ak), 12'h001);
		ex(7'h10); chk(pa, p);
		ex(7'h30); p = xa; chk(pa, VEC_SW); chk(PC_W'(ak), 12'h000);
		ex(7'h10); chk(pa, p + PC_ONE);
	endtask
	task automatic t_stack;
		ex(0, 4'h4, 1);
		for (int i = 0; i < 6; i++) begin
			ex(7'h02); q[i] = xa + PC_ONE; chk(pa, {2'b01, 10'(wd(xa))});
		end
		for (int i = 0; i < 6; i++) begin
			ex(7'h10); chk(pa, q[i < 5 ? 5 - i : 5]);
		end
	endtask
	task automatic t_osc;
		@(posedge clk) rc <= 1;
		repeat (3) @(negedge clk);
		n = 0;
		repeat (8) @(negedge clk) n += osc;
		chk(PC_W'(n), 12'h004);
		@(posedge clk) rc <= 0;
		repeat (3) @(negedge clk);
		n = 0;
		repeat (8) @(negedge clk) n += osc + 2 * ice;
		chk(PC_W'(n), 12'h004);
	endtask
	task automatic t_pin;
		@(posedge clk) ext_n <= 0;
		repeat (6) @(negedge clk);
		chk(PC_W'(inr), 12'h001);
		@(posedge clk) ext_n <= 1;
		n = 0;
		while (inr !== 1'b0 && n < 20) @(negedge clk) n++;
		chk(PC_W'(inr), 12'h000);
		chk(pa, VEC_RESET); chk(PC_W'(pg), 12'h000);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			print_verdict();
		end
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1;
		n = 0;
		while (inr !== 1'b0 && n < 20) @(negedge clk) n++;
		t_branch();
		t_irq();
		t_stack();
		t_osc();
		t_pin();
		ex(0); chk(pa, 12'h000);
		print_verdict();
	end
endmodule

`default_nettype wire
